// file: core/cidec_pkg.sv
// Purpose : shared types and constants for the instruction decoder
// Assumes : 16-bit program words, four clock periods per instruction cycle
// Notes   : group codes follow the top bits of the opcode
package cidec_pkg;

  localparam int WORD_W      = 16;
  localparam int FILE_W      = 8;
  localparam int BANK_W      = 4;
  localparam int PHASES      = 4;
  localparam int PHASE_W     = 2;
  localparam int BASE_COUNT  = 75;
  localparam int EXT_COUNT   = 8;

  // field positions
  localparam int F_LSB       = 0;
  localparam int A_BIT       = 8;
  localparam int D_BIT       = 9;
  localparam int B_LSB       = 9;
  localparam int B_W         = 3;
  localparam int PFX_LSB     = 12;
  localparam int PFX_W       = 4;
  localparam int FSRSEL_LSB  = 4;
  localparam int FSRSEL_W    = 2;
  localparam int S_BIT       = 0;
  localparam int M_W         = 2;
  localparam int N_W         = 11;

  // second-word marker and first-word opcodes of the double-word set
  localparam logic [3:0] SECOND_PFX  = 4'hF;
  localparam logic [3:0] OP_MOVFF    = 4'hC;
  localparam logic [7:0] OP_CALL_HI  = 8'hEC;
  localparam logic [7:0] OP_GOTO_HI  = 8'hEF;
  localparam logic [7:0] OP_LFSR_HI  = 8'hEE;
  localparam logic [7:0] OP_GOTO_HI0 = 8'hEF;

  // quick-access region boundary and top bank; last sequencer phase
  localparam logic [7:0] QUICK_SPLIT = 8'h60;
  localparam logic [3:0] QUICK_HI_BANK = 4'hF;
  localparam logic [1:0] PHASE_LAST  = 2'h3;

  typedef enum logic [1:0] {
    CIDEC_GRP_BYTE,
    CIDEC_GRP_BIT,
    CIDEC_GRP_LIT,
    CIDEC_GRP_CTRL
  } cidec_group_t;

  typedef struct packed {
    logic                valid;
    cidec_group_t        group;
    logic [7:0]          opcode;
    logic [FILE_W-1:0]   file_sel;
    logic                dest_file;
    logic                access_bank;
    logic [B_W-1:0]      bit_num;
    logic [7:0]          literal;
    logic [FSRSEL_W-1:0] fsr_sel;
    logic                fast_mode;
    logic [M_W-1:0]      table_mode;
    logic [N_W-1:0]      prog_addr;
    logic [BANK_W+FILE_W-1:0] data_addr;
    logic                double_word;
    logic                second_word;
    logic                no_operation;
    logic                extended;
    logic [1:0]          cycles;
  } cidec_decode_t;

endpackage

// file: core/cidec_phase_gen.sv
// Purpose : four-phase sequencer giving one instruction cycle per four clocks
// Assumes : single clock domain
// Notes   : cycle_end pulses on the last phase
`timescale 1ns/1ps
module cidec_phase_gen #(
  parameter int PHASES_P = cidec_pkg::PHASES
) (
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  output logic      [cidec_pkg::PHASE_W-1:0] phase,
  output logic                              cycle_end
);
  import cidec_pkg::*;

  if (PHASES_P != PHASES) begin : g_bad_phases
    $error("phase count must be four");
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= '0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cycle_end <= 1'b0;
    end else begin
      cycle_end <= (phase == PHASE_LAST - 2'h1);
    end
  end
endmodule

// file: core/cidec_decoder.sv
// Purpose : instruction fetch-side decode of 16-bit program words
// Assumes : fetch_word is stable for the whole instruction cycle
// Notes   : one decode result per instruction cycle, registered
//
// Summary of operation
// - recognise 75 base instructions plus 8 extended stack-oriented ones.
// - most instructions use one 16-bit word; four use two words.
// - split each single word into opcode and operand fields.
// - double-word instructions span 32 bits; second word top nibble all ones.
// - a second word executed alone acts as no operation.
// - single word takes one cycle, two when test true or PC changes.
// - every double-word instruction takes two instruction cycles.
// - one instruction cycle is four clock periods from a phase sequencer.
// - byte operations decode file selector, destination and access selector.
// - destination zero writes working register, one writes the file register.
// - bit operations decode file selector, bit number and access selector.
// - literal operations take a literal, pointer selector, or nothing.
// - control operations take address, call/return mode, table mode, or nothing.
// - classify each instruction into byte, bit, literal or control groups.
`timescale 1ns/1ps
module cidec_decoder #(
  parameter int WORD_W_P = cidec_pkg::WORD_W
) (
  input  wire logic                            core_clk,
  input  wire logic                            rstn,
  input  wire logic [cidec_pkg::WORD_W-1:0]    fetch_word,
  input  wire logic [cidec_pkg::BANK_W-1:0]    bank_sel,
  input  wire logic                            cond_taken,
  output logic                                 fetch_req,
  output logic      [cidec_pkg::PHASE_W-1:0]   phase_out,
  output cidec_pkg::cidec_decode_t             decode_out,
  output logic                                 to_working_register,
  output logic                                 cycle_stall
);
  import cidec_pkg::*;

  // refuse package settings that the fixed field slicing below cannot serve
  if (WORD_W_P != WORD_W) begin : g_bad_word
    $error("program word must be 16 bits");
  end
  if (PFX_LSB + PFX_W != WORD_W) begin : g_bad_marker
    $error("second-word marker must fill the top bits of the word");
  end
  if (B_LSB + B_W > WORD_W || D_BIT >= WORD_W || A_BIT >= WORD_W) begin : g_bad_fields
    $error("operand fields must lie inside the program word");
  end
  if (N_W > WORD_W || FILE_W != 8) begin : g_bad_addr
    $error("address fields do not fit the program word");
  end

  logic [PHASE_W-1:0] phase;
  logic               cycle_end;
  logic               expect_second_reg;
  logic               expect_second_next;
  logic               extra_cycle_reg;
  cidec_decode_t      dec_next;

  localparam int ADDR_W = BANK_W + FILE_W;

  cidec_decode_t      nop_slot;
  cidec_group_t       group_next;
  logic [ADDR_W-1:0]  data_addr_next;
  logic               pair_first;
  logic               marker_word;
  logic               take_extra;

  cidec_phase_gen #(
    .PHASES_P (PHASES)
  ) u_phase (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  function automatic logic is_double_first(input logic [WORD_W-1:0] w);
    is_double_first = (w[15:12] == OP_MOVFF) ||
                      (w[15:8] == OP_CALL_HI) || (w[15:8] == 8'hED) ||
                      (w[15:8] == OP_GOTO_HI) ||
                      ((w[15:8] == OP_LFSR_HI) && (w[7:6] == 2'h0));
  endfunction

  function automatic logic is_extended(input logic [WORD_W-1:0] w);
    is_extended = (w[15:8] == 8'hE8) || (w[15:8] == 8'hE9) ||
                  (w[15:8] == 8'hEA) || (w[15:8] == 8'hEB) ||
                  (w[15:0] == 16'h0014);
  endfunction

  always_comb begin
    dec_next             = '0;
    dec_next.valid       = 1'b1;
    dec_next.opcode      = fetch_word[15:8];
    dec_next.file_sel    = fetch_word[F_LSB +: FILE_W];
    dec_next.access_bank = fetch_word[A_BIT];
    dec_next.dest_file   = fetch_word[D_BIT];
    dec_next.bit_num     = fetch_word[B_LSB +: B_W];
    dec_next.literal     = fetch_word[7:0];
    dec_next.fsr_sel     = fetch_word[FSRSEL_LSB +: FSRSEL_W];
    dec_next.fast_mode   = fetch_word[S_BIT];
    dec_next.table_mode  = fetch_word[M_W-1:0];
    dec_next.prog_addr   = fetch_word[N_W-1:0];
    dec_next.extended    = is_extended(fetch_word);
    dec_next.group       = group_next;
    dec_next.data_addr   = data_addr_next;
    if (expect_second_reg) begin
      dec_next.second_word  = 1'b1;
      dec_next.cycles       = 2'h2;
    end else if (marker_word) begin
      dec_next.second_word  = 1'b1;
      dec_next.no_operation = 1'b1;
      dec_next.group        = CIDEC_GRP_CTRL;
      dec_next.cycles       = 2'h1;
    end else if (pair_first) begin
      dec_next.double_word  = 1'b1;
      dec_next.cycles       = 2'h2;
    end else begin
      dec_next.cycles       = cond_taken ? 2'h2 : 2'h1;
    end
  end

  // group from the top opcode bits; pointer loads count as literal operations
  always_comb begin
    if (fetch_word[15:12] <= 4'h6 && fetch_word[15:8] >= 8'h10) begin
      group_next = CIDEC_GRP_BYTE;
    end else if (fetch_word[15:12] >= 4'h7 && fetch_word[15:12] <= 4'hB) begin
      group_next = CIDEC_GRP_BIT;
    end else if (fetch_word[15:12] == 4'hC) begin
      group_next = CIDEC_GRP_BYTE;
    end else if (fetch_word[15:12] == 4'h0 && fetch_word[11:8] != 4'h0) begin
      group_next = CIDEC_GRP_LIT;
    end else if (fetch_word[15:8] == OP_LFSR_HI) begin
      group_next = CIDEC_GRP_LIT;
    end else begin
      group_next = CIDEC_GRP_CTRL;
    end
  end

  // access selector clear: quick region, split between bank zero and the top bank
  always_comb begin
    if (!fetch_word[A_BIT]) begin
      data_addr_next = (fetch_word[7:0] < QUICK_SPLIT) ?
                       {4'h0, fetch_word[7:0]} : {QUICK_HI_BANK, fetch_word[7:0]};
    end else begin
      data_addr_next = {bank_sel, fetch_word[7:0]};
    end
  end

  // a taken test buys one extra slot, never for a word that belongs to a pair
  always_comb begin
    pair_first  = is_double_first(fetch_word);
    marker_word = (fetch_word[PFX_LSB +: PFX_W] == SECOND_PFX);
    take_extra  = cond_taken && !extra_cycle_reg && !expect_second_reg &&
                  !pair_first && !marker_word;
  end

  // the inserted slot shows a plain one-cycle no_operation
  always_comb begin
    nop_slot              = '0;
    nop_slot.valid        = 1'b1;
    nop_slot.group        = CIDEC_GRP_CTRL;
    nop_slot.no_operation = 1'b1;
    nop_slot.cycles       = 2'h1;
  end

  // the word shown during an inserted slot is dropped and cannot open a pair
  always_comb begin
    expect_second_next = expect_second_reg;
    if (cycle_end) begin
      expect_second_next = !expect_second_reg && !extra_cycle_reg &&
                           pair_first;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      expect_second_reg <= 1'b0;
    end else begin
      expect_second_reg <= expect_second_next;
    end
  end

  // the extra cycle of a taken test runs as a no_operation slot
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      extra_cycle_reg <= 1'b0;
    end else if (cycle_end) begin
      extra_cycle_reg <= take_extra;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      decode_out          <= '0;
      to_working_register <= 1'b0;
    end else if (cycle_end) begin
      if (extra_cycle_reg) begin
        decode_out          <= nop_slot;
        to_working_register <= 1'b0;
      end else begin
        decode_out          <= dec_next;
        to_working_register <= (dec_next.group == CIDEC_GRP_BYTE) &&
                               !dec_next.dest_file && !dec_next.second_word;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cycle_stall <= 1'b0;
    end else if (cycle_end) begin
      // high exactly while the inserted slot is on show
      cycle_stall <= extra_cycle_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fetch_req <= 1'b0;
    end else begin
      fetch_req <= (phase == PHASE_LAST);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_out <= '0;
    end else begin
      phase_out <= phase;
    end
  end
endmodule

// file: bench/cidec_dec_chk.sv
// Purpose : port checks on the decoder
// Assumes : results settle on the same edge that raises each fetch_req pulse
// Notes   : bound from tb
`timescale 1ns/1ps
module cidec_dec_chk (
  input wire logic                          core_clk,
  input wire logic                          rstn,
  input wire logic [cidec_pkg::WORD_W-1:0]  fetch_word,
  input wire logic [cidec_pkg::BANK_W-1:0]  bank_sel,
  input wire logic                          cond_taken,
  input wire logic                          fetch_req,
  input wire logic [cidec_pkg::PHASE_W-1:0] phase_out,
  input wire cidec_pkg::cidec_decode_t      decode_out,
  input wire logic                          to_working_register,
  input wire logic                          cycle_stall
);
  import cidec_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_gap; !fetch_req [*3] ##1 fetch_req; endsequence
  sequence s_hold; $stable(decode_out) [*2]; endsequence
  sequence s_stall; ##4 (cycle_stall && decode_out.no_operation); endsequence
  chk_fetch_gap: assert property (fetch_req |=> s_gap)
    else $error("fetch spacing wrong");
  chk_decode_hold: assert property (fetch_req |=> s_hold)
    else $error("decode changed mid cycle");
  chk_cycle_count: assert property (fetch_req |-> decode_out.cycles inside {2'h1, 2'h2})
    else $error("bad cycle count");
  chk_working_register_dest: assert property (fetch_req && decode_out.group == CIDEC_GRP_BYTE
    && !decode_out.no_operation |-> to_working_register == !decode_out.dest_file)
    else $error("destination flag wrong");
  chk_pair_second: assert property (fetch_req && decode_out.double_word
    |-> decode_out.cycles == 2'h2 ##4 decode_out.second_word)
    else $error("double word pairing wrong");
  chk_stall_after: assert property (fetch_req && decode_out.cycles == 2'h2
    && !decode_out.double_word && !decode_out.second_word |-> s_stall)
    else $error("extra slot missing");
  chk_single_clean: assert property (fetch_req && !cycle_stall && !decode_out.double_word
    && decode_out.cycles == 2'h1 |-> ##4 !cycle_stall)
    else $error("unexpected extra slot");
  chk_quick_addr: assert property (fetch_req && !decode_out.access_bank
    && decode_out.group inside {CIDEC_GRP_BYTE, CIDEC_GRP_BIT} |-> decode_out.data_addr ==
    ((decode_out.file_sel < QUICK_SPLIT) ? {4'h0, decode_out.file_sel}
    : {QUICK_HI_BANK, decode_out.file_sel}))
    else $error("quick region address wrong");
endmodule

// file: bench/cidec_prog_mem.sv
// Purpose : program memory model feeding the decoder
// Assumes : bit 16 of each entry is the taken flag
// Notes   : tb fills mem while reset is held
`timescale 1ns/1ps
module cidec_prog_mem (
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  input  wire logic                         fetch_req,
  output logic      [cidec_pkg::WORD_W-1:0] fetch_word,
  output logic                              cond_taken
);
  import cidec_pkg::*;
  logic [WORD_W:0] mem [0:15];
  logic [3:0]      pc_reg;
  // word only moves after a fetch request, so it holds over the cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_reg <= 4'h0;
    end else if (fetch_req) begin
      pc_reg <= pc_reg + 4'h1;
    end
  end
  assign fetch_word = mem[pc_reg][WORD_W-1:0];
  assign cond_taken = mem[pc_reg][WORD_W];
endmodule

// file: bench/tb.sv
// Purpose : self-checking bench for the decoder
// Assumes : one decode result per fetch_req pulse
// Notes   : every scenario reloads memory under reset
`timescale 1ns/1ps
module tb;
  import cidec_pkg::*;
  logic                core_clk = 1'b0;
  logic                rstn     = 1'b0;
  logic [BANK_W-1:0]   bank_sel = 4'h5;
  logic [WORD_W-1:0]   fetch_word;
  logic                cond_taken;
  logic                fetch_req;
  logic [PHASE_W-1:0]  phase_out;
  cidec_decode_t       decode_out;
  logic                to_working_register;
  logic                cycle_stall;
  int                  n_mismatch = 0;
  int                  compares   = 0;
  int                  gap;
  always #2 core_clk = ~core_clk;
  cidec_decoder i_dut (.core_clk(core_clk), .rstn(rstn), .fetch_word(fetch_word),
    .bank_sel(bank_sel), .cond_taken(cond_taken), .fetch_req(fetch_req),
    .phase_out(phase_out), .decode_out(decode_out),
    .to_working_register(to_working_register), .cycle_stall(cycle_stall));
  cidec_prog_mem i_mem (.core_clk(core_clk), .rstn(rstn), .fetch_req(fetch_req),
    .fetch_word(fetch_word), .cond_taken(cond_taken));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic load(input logic [16:0] w0, w1, w2, w3, w4);
    @(posedge core_clk);
    #1 rstn = 1'b0;
    for (int i = 0; i < 16; i++) i_mem.mem[i] = 17'h0;
    i_mem.mem[0] = w0;
    i_mem.mem[1] = w1;
    i_mem.mem[2] = w2;
    i_mem.mem[3] = w3;
    i_mem.mem[4] = w4;
    repeat (20) @(posedge core_clk);
    #1 rstn = 1'b1;
  endtask
  task automatic next_dec();
    gap = 0;
    do begin
      @(posedge core_clk);
      #1;
      gap++;
    end while (fetch_req !== 1'b1 && gap < 12);
  endtask
  task automatic byte_ops();
    load(17'h02412, 17'h02770, 17'h02685, 17'h0, 17'h0);
    next_dec();
    check("group", 16'(CIDEC_GRP_BYTE), 16'(decode_out.group));
    check("phase", 16'h3, 16'(phase_out));
    check("to_working_register", 16'h1, 16'(to_working_register));
    check("addr", 16'h0012, 16'(decode_out.data_addr));
    next_dec();
    check("gap", 16'(PHASES), 16'(gap));
    check("dest", 16'h1, 16'(decode_out.dest_file));
    check("addr", 16'h0570, 16'(decode_out.data_addr));
    next_dec();
    check("file", 16'h0085, 16'(decode_out.file_sel));
    check("addr", 16'h0F85, 16'(decode_out.data_addr));
    check("cycles", 16'h1, 16'(decode_out.cycles));
  endtask
  task automatic bit_ops();
    load(17'h08B34, 17'h09E0A, 17'h0, 17'h0, 17'h0);
    next_dec();
    check("group", 16'(CIDEC_GRP_BIT), 16'(decode_out.group));
    check("bit", 16'h5, 16'(decode_out.bit_num));
    check("addr", 16'h0534, 16'(decode_out.data_addr));
    next_dec();
    check("bit", 16'h7, 16'(decode_out.bit_num));
    check("addr", 16'h000A, 16'(decode_out.data_addr));
  endtask
  task automatic lit_ctrl();
    load(17'h00E5A, 17'h0EE20, 17'h0F0AB, 17'h0EF12, 17'h0F345);
    next_dec();
    check("literal", 16'h005A, 16'(decode_out.literal));
    next_dec();
    check("pointer", 16'h2, 16'(decode_out.fsr_sel));
    check("cycles", 16'h2, 16'(decode_out.cycles));
    next_dec();
    check("second", 16'h1, 16'(decode_out.second_word));
    next_dec();
    check("group", 16'(CIDEC_GRP_CTRL), 16'(decode_out.group));
    check("double", 16'h1, 16'(decode_out.double_word));
    check("opcode", 16'h00EF, 16'(decode_out.opcode));
    check("target", 16'h0712, 16'(decode_out.prog_addr));
    next_dec();
    check("second", 16'h1, 16'(decode_out.second_word));
  endtask
  task automatic lone_word();
    load(17'h0F123, 17'h0E805, 17'h00014, 17'h00013, 17'h0000A);
    next_dec();
    check("nop", 16'h1, 16'(decode_out.no_operation));
    check("second", 16'h1, 16'(decode_out.second_word));
    check("cycles", 16'h1, 16'(decode_out.cycles));
    next_dec();
    check("ext", 16'h1, 16'(decode_out.extended));
    next_dec();
    check("ext", 16'h1, 16'(decode_out.extended));
    next_dec();
    check("fast", 16'h1, 16'(decode_out.fast_mode));
    next_dec();
    check("table", 16'h2, 16'(decode_out.table_mode));
  endtask
  task automatic branch_stall();
    load(17'h1E305, 17'h02770, 17'h02412, 17'h0, 17'h0);
    next_dec();
    check("cycles", 16'h2, 16'(decode_out.cycles));
    check("stall", 16'h0, 16'(cycle_stall));
    next_dec();
    check("stall", 16'h1, 16'(cycle_stall));
    check("nop", 16'h1, 16'(decode_out.no_operation));
    check("cycles", 16'h1, 16'(decode_out.cycles));
    next_dec();
    check("stall", 16'h0, 16'(cycle_stall));
    check("dest", 16'h0, 16'(decode_out.dest_file));
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    byte_ops();
    bit_ops();
    lit_ctrl();
    lone_word();
    branch_stall();
    give_verdict();
  end
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
endmodule
bind cidec_decoder cidec_dec_chk i_chk (.core_clk(core_clk), .rstn(rstn),
  .fetch_word(fetch_word), .bank_sel(bank_sel), .cond_taken(cond_taken),
  .fetch_req(fetch_req), .phase_out(phase_out), .decode_out(decode_out),
  .to_working_register(to_working_register), .cycle_stall(cycle_stall));
